// file: three_wire_serial_pkg.sv
// Purpose: Shared constants, types and bit helpers for the three-wire serial port.
// Assumes: One 100 MHz system clock runs both ends; the processor clock is a tick of it.
// Notes:   Register offsets are byte addresses on the internal CPU bus.
package three_wire_serial_pkg;
   // Register offsets on the internal CPU bus.
   localparam logic [7:0] CTRL_OFFSET = 8'h0a;
   localparam logic [7:0] STAT_OFFSET = 8'h0b;
   localparam logic [7:0] DATA_OFFSET = 8'h0c;
   // Control register field positions; bits 3 to 1 read as zero.
   localparam int CTRL_IRQ_EN_BIT    = 7;
   localparam int CTRL_PORT_EN_BIT   = 6;
   localparam int CTRL_LSB_FIRST_BIT = 5;
   localparam int CTRL_MASTER_BIT    = 4;
   localparam int CTRL_RATE_BIT      = 0;
   // Status register field positions; bits 5 to 0 read as zero.
   localparam int STAT_DONE_BIT = 7;
   localparam int STAT_COLL_BIT = 6;
   // Reset and idle values.
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic       LINE_IDLE = 1'b1;
   localparam logic       OE_OFF    = 1'b1;
   localparam logic [2:0] LAST_BIT  = 3'h7;
   // Timing: the processor clock is one enable every PROC_TICK_CYCLES system cycles.
   localparam int SYS_CLK_NS       = 10;
   localparam int PROC_CLK_NS      = 40;
   localparam int PROC_TICK_CYCLES = (PROC_CLK_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
   localparam int SCK_DIV_FAST     = 2;
   localparam int SCK_DIV_SLOW     = 16;
   localparam logic [5:0] HALF_FAST = 6'(SCK_DIV_FAST / 2 * PROC_TICK_CYCLES - 1);
   localparam logic [5:0] HALF_SLOW = 6'(SCK_DIV_SLOW / 2 * PROC_TICK_CYCLES - 1);
   localparam int FAR_HALF_NS = 60;
   localparam logic [5:0] FAR_HALF = 6'(FAR_HALF_NS / SYS_CLK_NS - 1);
   // Transfer state, one-hot.
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_SHIFT = 3'b010,
      ST_HELD  = 3'b100
   } xfer_state_t;
   // Bit that leaves the shift register next, for either bit order.
   function automatic logic nextOutBit(input logic [7:0] s, input logic lsbFirst);
      return lsbFirst ? s[0] : s[7];
   endfunction
   // Shift register after one bit has left and one has arrived.
   function automatic logic [7:0] shiftInBit(input logic [7:0] s, input logic lsbFirst,
                                             input logic b);
      return lsbFirst ? {b, s[7:1]} : {s[6:0], b};
   endfunction
endpackage

// file: three_wire_serial_if.sv
// Purpose: Three-wire link between the port and its far partner.
// Assumes: A pull-up holds the clock and data lines high when nobody drives them.
// Notes:   Enables are active low; the device wins if both ends drive the clock.
`timescale 1ns/100ps
interface three_wire_serial_if;
   logic devSck;     // Device clock drive value.
   logic devSckOeN;  // Device clock enable, low drives.
   logic devSdo;     // Device data out drive value.
   logic devSdoOeN;  // Device data out enable, low drives.
   logic farSck;     // Far clock drive value.
   logic farSckOeN;  // Far clock enable, low drives.
   logic farSdo;     // Far data out, always driven.
   logic sckLine;    // Resolved clock wire.
   logic devSdoLine; // Resolved device data wire.

   // Wire resolution with the pull-up as the last resort.
   assign sckLine    = !devSckOeN ? devSck : (!farSckOeN ? farSck : 1'b1);
   assign devSdoLine = !devSdoOeN ? devSdo : 1'b1;

   modport device (input sckLine, farSdo, output devSck, devSckOeN, devSdo, devSdoOeN);
   modport far (input sckLine, devSdoLine, output farSck, farSckOeN, farSdo);
endinterface

// file: sck_edge_sync.sv
// Purpose: Brings the external serial clock into the system clock and finds its edges.
// Assumes: The line idles high.
// Notes:   Edges appear two system cycles after the wire moves.
`timescale 1ns/100ps
module sck_edge_sync (
   input  wire logic clk_sys, // System clock.
   input  wire logic reset,   // Synchronous reset, active high.
   input  wire logic lineIn,  // Raw serial clock wire.
   output logic      rise,    // One-cycle pulse on a rising edge.
   output logic      fall     // One-cycle pulse on a falling edge.
);
   typedef struct packed {
      logic stage1;
      logic stage2;
      logic stage3;
   } sync_t;
   localparam sync_t SYNC_RESET = '{default: three_wire_serial_pkg::LINE_IDLE};
   sync_t sync_q;
   sync_t sync_d;

   // Stage one feeds only stage two, so a metastable value never reaches the edge logic.
   always_comb
   begin
      sync_d.stage1 = lineIn;
      sync_d.stage2 = sync_q.stage1;
      sync_d.stage3 = sync_q.stage2;
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         sync_q <= SYNC_RESET;
      else
         sync_q <= sync_d;
   end

   // Edges compare the settled stages only.
   assign rise = sync_q.stage2 & ~sync_q.stage3;
   assign fall = ~sync_q.stage2 & sync_q.stage3;
endmodule // sck_edge_sync

// file: three_wire_serial_device.sv
// Purpose: Byte-wide three-wire serial port with master and slave operation.
// Assumes: CPU strobes last one cycle; far master half period is at least four cycles.
// Notes:   Registers answer on the internal CPU bus at their byte offsets.
// Summary of operation
// - Enabled port owns the three port lines.
// - Master drives clock pin, slave only listens.
// - Bit order control picks LSB or MSB first.
// - Master data write starts clock and transfer.
// - Master clock derives from the processor clock.
// - Incoming bits enter the same shift register.
// - Eight bits stop clock, set flag, request interrupt.
// - Slave in stop mode wakes on completion interrupt.
// - Data writes ignored while completion flag stands.
// - Data register is eight bits, CPU readable, writable.
// - Slave uses pin clock; rate bit unused there.
// - Three-bit pulse counter overflow sets completion flag.
// - Present data on falling, sample on rising.
// - Received byte replaces sent byte; one flag.
// - One byte takes exactly eight clock pulses.
// - Far master supplies the clock to slaves.
// - Master bit rate at most half bus clock.
// - Clock line sits high before port enable.
// - Rate bit: divide by two or sixteen.
// - Status read then data access clears flags.
// - Data access mid-transfer sets collision flag only.
// - Port disable resets control logic, frees pins.
`timescale 1ns/100ps
module three_wire_serial_device (
   input  wire logic                    clk_sys,  // System clock, 100 MHz.
   input  wire logic                    reset,    // Synchronous reset, active high.
   input  wire logic [7:0]              cpuAddr,  // CPU register address.
   input  wire logic                    cpuRd,    // CPU read strobe.
   input  wire logic                    cpuWr,    // CPU write strobe.
   input  wire logic [7:0]              cpuWdata, // CPU write data.
   output logic      [7:0]              cpuRdata, // Read data, one cycle after the strobe.
   input  wire logic                    stopMode, // CPU sits in stop mode.
   output logic                         irqReq,   // Completion interrupt request.
   output logic                         wakeReq,  // Stop-mode wakeup request.
   three_wire_serial_if.device          link      // Serial link pins.
);
   typedef struct packed {
      logic                              irqEn;
      logic                              portEn;
      logic                              lsbFirst;
      logic                              master;
      logic                              rateSel;
      three_wire_serial_pkg::xfer_state_t state;
      logic                              collision_flag;
      logic                              statSeen;
      logic [7:0]                        shift;
      logic [2:0]                        bitCnt;
      logic [5:0]                        halfCnt;
      logic                              sck;
      logic                              serial_out_line;
      logic                              sckOeN;
      logic                              sdoOeN;
      logic [7:0]                        rdata;
      logic                              irq;
      logic                              wake;
   } dev_t;

   localparam dev_t DEV_RESET = '{
      irqEn: 1'b0, portEn: 1'b0, lsbFirst: 1'b0, master: 1'b0, rateSel: 1'b0,
      state: three_wire_serial_pkg::ST_IDLE, collision_flag: 1'b0, statSeen: 1'b0,
      shift: three_wire_serial_pkg::REG_RESET, bitCnt: 3'h0, halfCnt: 6'h00,
      sck: three_wire_serial_pkg::LINE_IDLE, serial_out_line: three_wire_serial_pkg::LINE_IDLE,
      sckOeN: three_wire_serial_pkg::OE_OFF, sdoOeN: three_wire_serial_pkg::OE_OFF,
      rdata: three_wire_serial_pkg::REG_RESET, irq: 1'b0, wake: 1'b0};

   dev_t       q;
   dev_t       d;
   logic       extRise;
   logic       extFall;
   logic       masterMode;
   logic       slaveMode;
   logic       dataAccess;
   logic       flagStands;
   logic [5:0] halfLimit;
   logic [7:0] rd;

   // The external clock passes two flops before any edge is looked at.
   sck_edge_sync u_sck_sync (
      .clk_sys (clk_sys),
      .reset   (reset),
      .lineIn  (link.sckLine),
      .rise    (extRise),
      .fall    (extFall)
   );

   // Mode decode and rate choice for the generated clock.
   assign masterMode = q.portEn & q.master;
   assign slaveMode  = q.portEn & ~q.master;
   assign flagStands = (q.state == three_wire_serial_pkg::ST_HELD);
   assign dataAccess = (cpuRd | cpuWr) & (cpuAddr == three_wire_serial_pkg::DATA_OFFSET);
   // The fastest choice is two processor clocks a bit, so the rate never passes half.
   assign halfLimit  = q.rateSel ? three_wire_serial_pkg::HALF_SLOW
                                 : three_wire_serial_pkg::HALF_FAST;

   // Next state: link engine first, then the CPU side, then the pin and request outputs.
   always_comb
   begin
      rd = three_wire_serial_pkg::REG_RESET;
      d  = q;
      unique case (q.state)
         three_wire_serial_pkg::ST_IDLE:
         begin
            // A slave starts on the first falling edge the far master makes.
            if (slaveMode && extFall)
            begin
               d.state  = three_wire_serial_pkg::ST_SHIFT;
               d.bitCnt = 3'h0;
               d.serial_out_line    = three_wire_serial_pkg::nextOutBit(q.shift, q.lsbFirst);
            end
         end
         three_wire_serial_pkg::ST_SHIFT:
         begin
            if (masterMode)
            begin
               // Master half periods count system cycles on the processor clock grid.
               if (q.halfCnt == halfLimit)
               begin
                  d.halfCnt = 6'h00;
                  if (q.sck)
                  begin
                     d.sck = 1'b0;
                     d.serial_out_line = three_wire_serial_pkg::nextOutBit(q.shift, q.lsbFirst);
                  end
                  else
                  begin
                     d.sck    = 1'b1;
                     d.shift  = three_wire_serial_pkg::shiftInBit(q.shift, q.lsbFirst,
                                                                  link.farSdo);
                     d.bitCnt = q.bitCnt + 3'h1;
                     // Counter wrap ends the byte; the clock stays high afterwards.
                     if (q.bitCnt == three_wire_serial_pkg::LAST_BIT)
                        d.state = three_wire_serial_pkg::ST_HELD;
                  end
               end
               else
                  d.halfCnt = q.halfCnt + 6'h01;
            end
            else
            begin
               // Slave follows the pin clock only; the rate bit plays no part here.
               if (extFall)
                  d.serial_out_line = three_wire_serial_pkg::nextOutBit(q.shift, q.lsbFirst);
               if (extRise)
               begin
                  d.shift  = three_wire_serial_pkg::shiftInBit(q.shift, q.lsbFirst,
                                                               link.farSdo);
                  d.bitCnt = q.bitCnt + 3'h1;
                  if (q.bitCnt == three_wire_serial_pkg::LAST_BIT)
                     d.state = three_wire_serial_pkg::ST_HELD;
               end
            end
         end
         three_wire_serial_pkg::ST_HELD:
         begin
            // Further clock edges are ignored while the flag stands, so no ninth bit.
            d.state = q.state;
         end
         default:
            d.state = three_wire_serial_pkg::ST_IDLE;
      endcase

      // Register reads; the data register shows the received byte after a transfer.
      if (cpuRd)
      begin
         if (cpuAddr == three_wire_serial_pkg::CTRL_OFFSET)
         begin
            rd[three_wire_serial_pkg::CTRL_IRQ_EN_BIT]    = q.irqEn;
            rd[three_wire_serial_pkg::CTRL_PORT_EN_BIT]   = q.portEn;
            rd[three_wire_serial_pkg::CTRL_LSB_FIRST_BIT] = q.lsbFirst;
            rd[three_wire_serial_pkg::CTRL_MASTER_BIT]    = q.master;
            rd[three_wire_serial_pkg::CTRL_RATE_BIT]      = q.rateSel;
         end
         else if (cpuAddr == three_wire_serial_pkg::STAT_OFFSET)
         begin
            rd[three_wire_serial_pkg::STAT_DONE_BIT] = flagStands;
            rd[three_wire_serial_pkg::STAT_COLL_BIT] = q.collision_flag;
            // First half of the clearing sequence.
            if (flagStands)
               d.statSeen = 1'b1;
         end
         else if (cpuAddr == three_wire_serial_pkg::DATA_OFFSET)
            rd = q.shift;
         d.rdata = rd;
      end

      // Data register accesses.
      if (dataAccess)
      begin
         if (q.state == three_wire_serial_pkg::ST_SHIFT)
            d.collision_flag = 1'b1;
         else
         begin
            if (flagStands && q.statSeen)
            begin
               d.state    = three_wire_serial_pkg::ST_IDLE;
               d.collision_flag     = 1'b0;
               d.statSeen = 1'b0;
            end
            // A write while the flag stands unacknowledged is dropped.
            if (cpuWr && (!flagStands || q.statSeen))
            begin
               d.shift = cpuWdata;
               if (masterMode)
               begin
                  d.state   = three_wire_serial_pkg::ST_SHIFT;
                  d.bitCnt  = 3'h0;
                  d.halfCnt = 6'h00;
                  d.sck     = three_wire_serial_pkg::LINE_IDLE;
               end
            end
         end
      end

      // Control writes; clearing the enable returns state, flags, counters and clock drive to idle; the data out value keeps its level.
      if (cpuWr && (cpuAddr == three_wire_serial_pkg::CTRL_OFFSET))
      begin
         d.irqEn    = cpuWdata[three_wire_serial_pkg::CTRL_IRQ_EN_BIT];
         d.portEn   = cpuWdata[three_wire_serial_pkg::CTRL_PORT_EN_BIT];
         d.lsbFirst = cpuWdata[three_wire_serial_pkg::CTRL_LSB_FIRST_BIT];
         d.master   = cpuWdata[three_wire_serial_pkg::CTRL_MASTER_BIT];
         d.rateSel  = cpuWdata[three_wire_serial_pkg::CTRL_RATE_BIT];
         if (!cpuWdata[three_wire_serial_pkg::CTRL_PORT_EN_BIT])
         begin
            d.state    = three_wire_serial_pkg::ST_IDLE;
            d.collision_flag     = 1'b0;
            d.statSeen = 1'b0;
            d.bitCnt   = 3'h0;
            d.halfCnt  = 6'h00;
            d.sck      = three_wire_serial_pkg::LINE_IDLE;
         end
      end

      // Pin ownership follows enable and mode only; the general direction bits never matter.
      d.sckOeN = ~(d.portEn & d.master);
      d.sdoOeN = ~d.portEn;
      // A master holds its request back in stop mode; a slave may raise it to wake the CPU.
      d.irq  = d.portEn & d.irqEn & (d.state == three_wire_serial_pkg::ST_HELD)
               & (~stopMode | ~d.master);
      d.wake = stopMode & d.portEn & ~d.master & d.irqEn
               & (d.state == three_wire_serial_pkg::ST_HELD);
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         q <= DEV_RESET;
      else
         q <= d;
   end

   // Every output leaves straight from the state register.
   assign cpuRdata       = q.rdata;
   assign irqReq         = q.irq;
   assign wakeReq        = q.wake;
   assign link.devSck    = q.sck;
   assign link.devSckOeN = q.sckOeN;
   assign link.devSdo    = q.serial_out_line;
   assign link.devSdoOeN = q.sdoOeN;
endmodule // three_wire_serial_device

// file: three_wire_serial_far.sv
// Purpose: Far partner of the serial port, acting as master or slave.
// Assumes: Link wires are synchronous to the shared system clock.
// Notes:   As slave it must be armed by start before the device master begins.
`timescale 1ns/100ps
module three_wire_serial_far (
   input  wire logic           clk_sys,   // System clock, 100 MHz.
   input  wire logic           reset,     // Synchronous reset, active high.
   input  wire logic           farMaster, // High: this end makes the clock.
   input  wire logic           start,     // Pulse: load txByte and run or arm.
   input  wire logic [7:0]     txByte,    // Byte to send.
   input  wire logic           lsbFirst,  // High: least significant bit first.
   output logic      [7:0]     rxByte,    // Last byte received.
   output logic                done,      // Pulse: rxByte is new.
   output logic                busy,      // Transfer armed or running.
   three_wire_serial_if.far    link       // Serial link pins.
);
   typedef struct packed {
      three_wire_serial_pkg::xfer_state_t state;
      logic [7:0]                        shift;
      logic [2:0]                        bitCnt;
      logic [5:0]                        halfCnt;
      logic                              sck;
      logic                              sckOeN;
      logic                              serial_out_line;
      logic                              sckPrev;
      logic [7:0]                        rx;
      logic                              done;
      logic                              busy;
   } far_t;

   localparam far_t FAR_RESET = '{
      state: three_wire_serial_pkg::ST_IDLE, shift: three_wire_serial_pkg::REG_RESET,
      bitCnt: 3'h0, halfCnt: 6'h00, sck: three_wire_serial_pkg::LINE_IDLE,
      sckOeN: three_wire_serial_pkg::OE_OFF, serial_out_line: three_wire_serial_pkg::LINE_IDLE,
      sckPrev: three_wire_serial_pkg::LINE_IDLE, rx: three_wire_serial_pkg::REG_RESET,
      done: 1'b0, busy: 1'b0};

   far_t q;
   far_t d;
   logic lineFall;
   logic lineRise;

   // The wire is synchronous here, so one history flop is enough to see edges.
   assign lineFall = q.sckPrev & ~link.sckLine;
   assign lineRise = ~q.sckPrev & link.sckLine;

   // Next state of the partner engine.
   always_comb
   begin
      d         = q;
      d.done    = 1'b0;
      d.sckPrev = link.sckLine;
      unique case (q.state)
         three_wire_serial_pkg::ST_IDLE:
         begin
            if (start)
            begin
               d.state   = three_wire_serial_pkg::ST_SHIFT;
               d.shift   = txByte;
               d.bitCnt  = 3'h0;
               d.halfCnt = 6'h00;
               d.sck     = three_wire_serial_pkg::LINE_IDLE;
            end
         end
         three_wire_serial_pkg::ST_SHIFT:
         begin
            if (farMaster)
            begin
               // Master makes eight pulses, data out on fall, sample on rise.
               if (q.halfCnt == three_wire_serial_pkg::FAR_HALF)
               begin
                  d.halfCnt = 6'h00;
                  d.sck     = ~q.sck;
                  if (q.sck)
                     d.serial_out_line = three_wire_serial_pkg::nextOutBit(q.shift, lsbFirst);
                  else
                  begin
                     d.shift  = three_wire_serial_pkg::shiftInBit(q.shift, lsbFirst,
                                                                  link.devSdoLine);
                     d.bitCnt = q.bitCnt + 3'h1;
                     if (q.bitCnt == three_wire_serial_pkg::LAST_BIT)
                        d.state = three_wire_serial_pkg::ST_HELD;
                  end
               end
               else
                  d.halfCnt = q.halfCnt + 6'h01;
            end
            else
            begin
               // Slave follows the device clock edge by edge.
               if (lineFall)
                  d.serial_out_line = three_wire_serial_pkg::nextOutBit(q.shift, lsbFirst);
               if (lineRise)
               begin
                  d.shift  = three_wire_serial_pkg::shiftInBit(q.shift, lsbFirst,
                                                               link.devSdoLine);
                  d.bitCnt = q.bitCnt + 3'h1;
                  if (q.bitCnt == three_wire_serial_pkg::LAST_BIT)
                     d.state = three_wire_serial_pkg::ST_HELD;
               end
            end
         end
         three_wire_serial_pkg::ST_HELD:
         begin
            d.rx    = q.shift;
            d.done  = 1'b1;
            d.state = three_wire_serial_pkg::ST_IDLE;
         end
         default:
            d.state = three_wire_serial_pkg::ST_IDLE;
      endcase
      // As master the clock is driven high while idle, so the line is high before enable.
      d.sckOeN = ~farMaster;
      d.busy   = (d.state != three_wire_serial_pkg::ST_IDLE);
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         q <= FAR_RESET;
      else
         q <= d;
   end

   assign rxByte         = q.rx;
   assign done           = q.done;
   assign busy           = q.busy;
   assign link.farSck    = q.sck;
   assign link.farSckOeN = q.sckOeN;
   assign link.farSdo    = q.serial_out_line;
endmodule // three_wire_serial_far

// file: three_wire_serial_props.sv
// Purpose: Wire timing checks between the serial port and its far end.
// Assumes: Both ends share clk_sys; fast rate gives four-cycle clock halves.
// Notes:   Sees only interface signals, so rate is bounded, not decoded.
`timescale 1ns/100ps
module three_wire_serial_props (
   input wire logic clk_sys,    // System clock.
   input wire logic reset,      // Synchronous reset.
   input wire logic devSck,     // Device clock value.
   input wire logic devSckOeN,  // Device clock enable, low drives.
   input wire logic devSdoOeN,  // Device data enable, low drives.
   input wire logic farSck,     // Far clock value.
   input wire logic farSckOeN,  // Far clock enable, low drives.
   input wire logic farSdo,     // Far data out.
   input wire logic sckLine,    // Resolved clock wire.
   input wire logic devSdoLine  // Resolved device data wire.
);
   // One domain, so clock and reset are given once for all checks.
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   // Data must sit still on the sampling edge, so both ends only move it between rises.
   a_dev_rise_stable: assert property ($rose(sckLine) |-> $stable(devSdoLine)) else $error("device data moved on rise");
   a_far_rise_stable: assert property ($rose(sckLine) |-> $stable(farSdo)) else $error("far data moved on rise");
   a_master_owns_pins: assert property (!devSckOeN |-> !devSdoOeN) else $error("master clock without data pin");
   a_one_clock_src: assert property (!devSckOeN |-> farSckOeN) else $error("two clock drivers");
   a_low_half_min: assert property ($fell(devSck) |-> !devSck [*4]) else $error("clock low too short");
   a_low_half_max: assert property ($fell(devSck) |-> ##[4:32] $rose(devSck)) else $error("clock low too long");
   a_high_half_min: assert property ($rose(devSck) && !devSckOeN |-> devSck [*4]) else $error("clock high too short");
   a_far_half: assert property ($fell(farSck) |-> !farSck [*6] ##1 farSck) else $error("far half period wrong");
endmodule // three_wire_serial_props

// file: three_wire_serial_port_tb.sv
// Purpose: Self-checking bench with the port facing its far end.
// Assumes: A far slave is armed before the device master writes data.
// Notes:   Waits are bounded; a watchdog ends a hang.
`timescale 1ns/100ps
module three_wire_serial_port_tb;
   localparam logic [7:0] CTL = three_wire_serial_pkg::CTRL_OFFSET;
   localparam logic [7:0] STA = three_wire_serial_pkg::STAT_OFFSET;
   localparam logic [7:0] DAT = three_wire_serial_pkg::DATA_OFFSET;
   logic       clk_sys, reset, cpuRd, cpuWr, stopMode, irqReq, wakeReq;
   logic       farMaster, start, lsbFirst, done, busy;
   logic [7:0] cpuAddr, cpuWdata, cpuRdata, txByte, rxByte;
   int         n_mismatch, num_checks, nRise, cyc, nDone;

   // Both ends face each other; the checker watches the wires between them.
   three_wire_serial_if lnk ();
   three_wire_serial_device u_three_wire_serial_device (.clk_sys, .reset, .cpuAddr, .cpuRd,
      .cpuWr, .cpuWdata, .cpuRdata, .stopMode, .irqReq, .wakeReq, .link(lnk));
   three_wire_serial_far u_three_wire_serial_far (.clk_sys, .reset, .farMaster, .start,
      .txByte, .lsbFirst, .rxByte, .done, .busy, .link(lnk));
   three_wire_serial_props u_three_wire_serial_props (.clk_sys, .reset, .devSck(lnk.devSck),
      .devSckOeN(lnk.devSckOeN), .devSdoOeN(lnk.devSdoOeN), .farSck(lnk.farSck),
      .farSckOeN(lnk.farSckOeN), .farSdo(lnk.farSdo), .sckLine(lnk.sckLine),
      .devSdoLine(lnk.devSdoLine));

   // Free-running clock; pulses on the wire are counted whoever drives it.
   initial
   begin
      clk_sys = 1'h0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge lnk.sckLine) nRise++;
   // Far completion pulses are counted so a lost or doubled byte shows up.
   always @(posedge clk_sys) if (done === 1'h1) nDone++;

   // Comparison, bus cycles and waits; inputs move on the falling edge only.
   task automatic chk(input string what, input logic [7:0] exp, got);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(negedge clk_sys);
      {cpuAddr, cpuWdata, cpuWr} = {a, d, 1'h1};
      @(negedge clk_sys);
      cpuWr = 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, exp);
      @(negedge clk_sys);
      {cpuAddr, cpuRd} = {a, 1'h1};
      @(negedge clk_sys);
      cpuRd = 1'h0;
      chk($sformatf("reg %h", a), exp, cpuRdata);
   endtask
   task automatic arm(input logic m, lsb, input logic [7:0] b);
      @(negedge clk_sys);
      {farMaster, lsbFirst, txByte, start} = {m, lsb, b, 1'h1};
      @(negedge clk_sys);
      start = 1'h0;
   endtask
   // The interrupt alone may come before the far end finishes, so both are awaited.
   task automatic waitDone;
      cyc = 0;
      while (!(irqReq === 1'h1 && busy === 1'h0) && cyc < 2000)
      begin
         @(negedge clk_sys);
         cyc++;
      end
      chk("wait", 8'h01, 8'(cyc < 2000));
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Watchdog, well beyond the roughly 740 cycles the tests take.
   initial
   begin
      #50us;
      n_mismatch++;
      end_sim();
   end

   // Reset, then master fast MSB-first, master slow LSB-first, slave in stop mode.
   initial
   begin
      {cpuRd, cpuWr, stopMode, farMaster, start, lsbFirst} = 6'h0;
      {cpuAddr, cpuWdata, txByte} = 24'h0;
      {n_mismatch, num_checks, nRise, nDone} = 0;
      reset = 1'h1;
      repeat (16) @(negedge clk_sys);
      reset = 1'h0;
      rd(CTL, 8'h00);
      rd(STA, 8'h00);
      rd(8'h0d, 8'h00);
      arm(1'h0, 1'h0, 8'hc3);
      wr(CTL, 8'hd0);
      chk("pin enables", 8'h00, {6'h0, lnk.devSckOeN, lnk.devSdoOeN});
      nRise = 0;
      wr(DAT, 8'h5a);
      wr(DAT, 8'h77);
      waitDone();
      chk("fast time", 8'h01, 8'(cyc > 55 && cyc < 72));
      chk("pulses", 8'h08, 8'(nRise));
      chk("far rx", 8'h5a, rxByte);
      wr(DAT, 8'hff);
      rd(STA, 8'hc0);
      rd(DAT, 8'hc3);
      rd(STA, 8'h00);
      chk("irq", 8'h00, {7'h0, irqReq});
      arm(1'h0, 1'h1, 8'ha6);
      wr(CTL, 8'hf1);
      wr(DAT, 8'h3c);
      waitDone();
      chk("slow time", 8'h01, 8'(cyc > 505 && cyc < 525));
      chk("far rx", 8'h3c, rxByte);
      rd(STA, 8'h80);
      rd(DAT, 8'ha6);
      stopMode = 1'h1;
      wr(CTL, 8'hc1);
      chk("pin enables", 8'h02, {6'h0, lnk.devSckOeN, lnk.devSdoOeN});
      wr(DAT, 8'h96);
      arm(1'h1, 1'h0, 8'h69);
      waitDone();
      chk("wake", 8'h01, {7'h0, wakeReq});
      chk("far rx", 8'h96, rxByte);
      rd(STA, 8'h80);
      rd(DAT, 8'h69);
      wr(CTL, 8'h00);
      chk("pin enables", 8'h03, {6'h0, lnk.devSckOeN, lnk.devSdoOeN});
      chk("far done", 8'h03, 8'(nDone));
      end_sim();
   end
endmodule // three_wire_serial_port_tb
